//--- logic/ext_irq_defines.svh
// Register offsets, field positions, reset values and timing counts of the external pin interrupt unit
//
// Contract
// - Group 1 flags when any masked-in input among positions 15..8 toggles.
// - Group 0 flags when any masked-in input among positions 7..0 toggles.
// - Pins driven as outputs still trigger; detection ignores pin direction.
// - Pin-change activity is seen without a running core, and raises wake.
// - Sense 00 low level, 01 any change, 10 falling, 11 rising edge.
// - Enabled low-level sense requests for as long as the pin stays low.
// - Edges are recognised only while the clock runs.
// - Pins are sampled before edge detection; pulses over one period are caught.
// - A level gone before start-up ends gives wake but no interrupt; here wake and request follow the same sampled level, with no start-up delay.
// - External requests reach their vector only with source and global enables.
// - Edge flag sets on trigger, clears on handler entry or written one.
// - Flag of a request in low-level sense is held cleared.
// - Group 1 requests need group enable and global enable; mask selects pins.
// - Group 0 requests need group enable and global enable; mask selects pins.
// - Unused bits of sense, enable, flag and group registers read zero.
// - Sense field of request 1 in bits 3..2, request 0 in bits 1..0.
// - Group flag sets on masked change, clears on handler entry or one.
// - Each pin-change input has one mask bit in its group's mask.
`ifndef EXT_IRQ_DEFINES_SVH
`define EXT_IRQ_DEFINES_SVH

// Byte offsets on the register bus
`define OFS_SENSE_CONTROL    5'h00
`define OFS_EXT_ENABLE       5'h04
`define OFS_EXT_FLAGS        5'h08
`define OFS_GROUP_ENABLE     5'h0c
`define OFS_GROUP_FLAGS      5'h10
`define OFS_MASK_GROUP0      5'h14
`define OFS_MASK_GROUP1      5'h18
`define OFS_PIN_STATE        5'h1c

// Field positions
`define SENSE1_LSB           2
`define SENSE0_LSB           0
`define EXT_BIT_1            1
`define EXT_BIT_0            0
`define GROUP_BIT_1          1
`define GROUP_BIT_0          0

// Request output positions
`define REQ_EXT0             0
`define REQ_EXT1             1
`define REQ_GROUP0           2
`define REQ_GROUP1           3

// Reset values
`define RST_SENSE_CONTROL    4'h0
`define RST_EXT_ENABLE       2'h0
`define RST_EXT_FLAGS        2'h0
`define RST_GROUP_ENABLE     2'h0
`define RST_GROUP_FLAGS      2'h0
`define RST_MASK             8'h00

// Cycles after reset release before pin history counts as valid
`define SAMPLER_PRIME_CYCLES 2'h3

`endif

//--- logic/ext_irq_pkg.sv
// Types shared by the external pin interrupt unit
package ext_irq_pkg;

    typedef enum logic [1:0] {
        SENSE_LOW  = 2'b00,
        SENSE_ANY  = 2'b01,
        SENSE_FALL = 2'b10,
        SENSE_RISE = 2'b11
    } sense_e;

    typedef enum logic [0:0] {
        BUS_IDLE   = 1'b0,
        BUS_ANSWER = 1'b1
    } bus_state_e;

endpackage

//--- logic/pin_sample_if.sv
// Synchronised pin levels and change pulses passed from the sampler to the controller
`timescale 1ns/1ps
interface pin_sample_if;
    logic [1:0]  ext_level;
    logic [1:0]  ext_rise;
    logic [1:0]  ext_fall;
    logic [15:0] pc_level;
    logic [15:0] pc_change;

    modport source (
        output ext_level,
        output ext_rise,
        output ext_fall,
        output pc_level,
        output pc_change
    );

    modport sink (
        input ext_level,
        input ext_rise,
        input ext_fall,
        input pc_level,
        input pc_change
    );
endinterface

//--- logic/pin_sampler.sv
// Two-stage synchronisers and change detection for request and pin-change inputs
`timescale 1ns/1ps
`include "ext_irq_defines.svh"
module pin_sampler (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Raw pins
    input  wire logic [1:0]  ext_pin,
    input  wire logic [15:0] pc_pin,
    // Sampled view
    pin_sample_if.source     smp
);
    import ext_irq_pkg::*;

    logic [17:0] meta;
    logic [17:0] stable;
    logic [17:0] last;
    logic [1:0]  prime;
    logic        primed;
    logic [17:0] rise;
    logic [17:0] fall;

    ////////////////////////////////////////////////////////////////////////////////
    // Pins are read regardless of direction, so software driving them still triggers

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta   <= 18'h00000;
            stable <= 18'h00000;
            last   <= 18'h00000;
        end else begin
            meta   <= {ext_pin, pc_pin};
            stable <= meta;
            last   <= stable;
        end
    end

    // History holds reset zeros at first; suppress changes until it has filled
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prime <= 2'h0;
        end else if (!primed) begin
            prime <= prime + 2'h1;
        end
    end

    assign primed = (prime == `SAMPLER_PRIME_CYCLES);
    assign rise   = primed ? (stable & ~last) : 18'h00000;
    assign fall   = primed ? (~stable & last) : 18'h00000;

    assign smp.ext_level = stable[17:16];
    assign smp.ext_rise  = rise[17:16];
    assign smp.ext_fall  = fall[17:16];
    assign smp.pc_level  = stable[15:0];
    assign smp.pc_change = rise[15:0] | fall[15:0];

endmodule

//--- logic/ext_pin_irq.sv
// External pin interrupt controller with Avalon-MM register slave
//
// Our own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "ext_irq_defines.svh"
module ext_pin_irq (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_B,
    // Pins
    input  wire logic [1:0]  EXT_REQUEST_PINS,
    input  wire logic [15:0] PIN_CHANGE_INPUTS,
    // Core interrupt logic
    input  wire logic        GLOBAL_INT_ENABLE,
    input  wire logic [3:0]  HANDLER_ENTERED,
    output logic      [3:0]  IRQ_REQUEST,
    output logic             WAKE_REQUEST,
    // Avalon-MM slave
    input  wire logic [4:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST
);
    import ext_irq_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Functions

    // Trigger condition of an edge or change sense; low level is handled apart
    function automatic logic edge_trigger(input sense_e sense, input logic rise,
                                          input logic fall);
        logic hit;
        hit = 1'b0;
        case (sense)
            SENSE_LOW:  hit = 1'b0;
            SENSE_ANY:  hit = rise | fall;
            SENSE_FALL: hit = fall;
            SENSE_RISE: hit = rise;
            default:    hit = 1'b0;
        endcase
        return hit;
    endfunction

    // Any change on a masked-in pin of one group
    function automatic logic group_change(input logic [7:0] change, input logic [7:0] mask);
        return |(change & mask);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Pin sampling

    pin_sample_if smp ();

    pin_sampler u_sampler (
        .clk     (CLK),
        .rst_b   (RST_B),
        .ext_pin (EXT_REQUEST_PINS),
        .pc_pin  (PIN_CHANGE_INPUTS),
        .smp     (smp)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [3:0]  sense_control;
    logic [1:0]  external_request_enable;
    logic [1:0]  external_request_flags;
    logic [1:0]  pin_change_group_enable;
    logic [1:0]  group_flags;
    logic [7:0]  pin_change_mask_group0;
    logic [7:0]  pin_change_mask_group1;

    bus_state_e  bus_state;
    bus_state_e  next_bus_state;

    logic        access;
    logic        fire_write;
    logic        low_lane;
    logic        sel_sense;
    logic        sel_ext_enable;
    logic        sel_ext_flags;
    logic        sel_group_enable;
    logic        sel_group_flags;
    logic        sel_mask0;
    logic        sel_mask1;
    logic        sel_pin_state;
    logic [7:0]  wbyte;
    logic [31:0] read_word;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    assign access           = AVS_READ | AVS_WRITE;
    assign fire_write       = AVS_WRITE & ~AVS_WAITREQUEST;
    assign low_lane         = AVS_BYTEENABLE[0];
    assign wbyte            = AVS_WRITEDATA[7:0];
    assign sel_sense        = (AVS_ADDRESS == `OFS_SENSE_CONTROL);
    assign sel_ext_enable   = (AVS_ADDRESS == `OFS_EXT_ENABLE);
    assign sel_ext_flags    = (AVS_ADDRESS == `OFS_EXT_FLAGS);
    assign sel_group_enable = (AVS_ADDRESS == `OFS_GROUP_ENABLE);
    assign sel_group_flags  = (AVS_ADDRESS == `OFS_GROUP_FLAGS);
    assign sel_mask0        = (AVS_ADDRESS == `OFS_MASK_GROUP0);
    assign sel_mask1        = (AVS_ADDRESS == `OFS_MASK_GROUP1);
    assign sel_pin_state    = (AVS_ADDRESS == `OFS_PIN_STATE);

    // Unused bits and unmapped addresses read as zero
    assign read_word =
        sel_sense        ? {28'h0000000, sense_control} :
        sel_ext_enable   ? {30'h00000000, external_request_enable} :
        sel_ext_flags    ? {30'h00000000, external_request_flags} :
        sel_group_enable ? {30'h00000000, pin_change_group_enable} :
        sel_group_flags  ? {30'h00000000, group_flags} :
        sel_mask0        ? {24'h000000, pin_change_mask_group0} :
        sel_mask1        ? {24'h000000, pin_change_mask_group1} :
        sel_pin_state    ? {14'h0000, smp.ext_level, smp.pc_level} :
                           32'h00000000;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle, then the answer for one cycle

    always_comb begin
        next_bus_state = bus_state;
        case (bus_state)
            BUS_IDLE:   next_bus_state = access ? BUS_ANSWER : BUS_IDLE;
            BUS_ANSWER: next_bus_state = BUS_IDLE;
            default:    next_bus_state = BUS_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            bus_state       <= BUS_IDLE;
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= 32'h00000000;
        end else begin
            bus_state       <= next_bus_state;
            AVS_WAITREQUEST <= (next_bus_state != BUS_ANSWER);
            if (bus_state == BUS_IDLE && AVS_READ) begin
                AVS_READDATA <= read_word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control registers

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            sense_control           <= `RST_SENSE_CONTROL;
            external_request_enable <= `RST_EXT_ENABLE;
            pin_change_group_enable <= `RST_GROUP_ENABLE;
            pin_change_mask_group0  <= `RST_MASK;
            pin_change_mask_group1  <= `RST_MASK;
        end else if (fire_write && low_lane) begin
            if (sel_sense) begin
                sense_control <= wbyte[3:0];
            end
            if (sel_ext_enable) begin
                external_request_enable <= wbyte[1:0];
            end
            if (sel_group_enable) begin
                pin_change_group_enable <= wbyte[1:0];
            end
            if (sel_mask0) begin
                pin_change_mask_group0 <= wbyte;
            end
            if (sel_mask1) begin
                pin_change_mask_group1 <= wbyte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flags: a set in the same cycle as a clear wins

    sense_e      sense1;
    sense_e      sense0;
    logic [1:0]  level_mode;
    logic [1:0]  ext_set;
    logic [1:0]  ext_clear;
    logic [1:0]  next_ext_flags;
    logic [1:0]  group_set;
    logic [1:0]  group_clear;
    logic [1:0]  next_group_flags;

    assign sense1 = sense_e'(sense_control[`SENSE1_LSB +: 2]);
    assign sense0 = sense_e'(sense_control[`SENSE0_LSB +: 2]);

    assign level_mode[`EXT_BIT_1] = (sense1 == SENSE_LOW);
    assign level_mode[`EXT_BIT_0] = (sense0 == SENSE_LOW);

    assign ext_set[`EXT_BIT_1] = edge_trigger(sense1, smp.ext_rise[1], smp.ext_fall[1]);
    assign ext_set[`EXT_BIT_0] = edge_trigger(sense0, smp.ext_rise[0], smp.ext_fall[0]);

    assign ext_clear[`EXT_BIT_1] = HANDLER_ENTERED[`REQ_EXT1]
                                 | (fire_write & low_lane & sel_ext_flags & wbyte[1]);
    assign ext_clear[`EXT_BIT_0] = HANDLER_ENTERED[`REQ_EXT0]
                                 | (fire_write & low_lane & sel_ext_flags & wbyte[0]);

    assign next_ext_flags = ~level_mode
                          & (ext_set | (external_request_flags & ~ext_clear));

    assign group_set[`GROUP_BIT_1] = group_change(smp.pc_change[15:8],
                                                  pin_change_mask_group1);
    assign group_set[`GROUP_BIT_0] = group_change(smp.pc_change[7:0],
                                                  pin_change_mask_group0);

    assign group_clear[`GROUP_BIT_1] = HANDLER_ENTERED[`REQ_GROUP1]
                                     | (fire_write & low_lane & sel_group_flags & wbyte[1]);
    assign group_clear[`GROUP_BIT_0] = HANDLER_ENTERED[`REQ_GROUP0]
                                     | (fire_write & low_lane & sel_group_flags & wbyte[0]);

    assign next_group_flags = group_set | (group_flags & ~group_clear);

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            external_request_flags <= `RST_EXT_FLAGS;
            group_flags            <= `RST_GROUP_FLAGS;
        end else begin
            external_request_flags <= next_ext_flags;
            group_flags            <= next_group_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Requests toward the core

    logic [1:0]  ext_active;
    logic [3:0]  next_request;
    logic        next_wake;

    // A low level requests directly and stops on the third clock edge after the pin rises again
    assign ext_active = (level_mode & ~smp.ext_level)
                      | (~level_mode & external_request_flags);

    assign next_request[`REQ_EXT1]   = GLOBAL_INT_ENABLE
                                     & external_request_enable[`EXT_BIT_1]
                                     & ext_active[`EXT_BIT_1];
    assign next_request[`REQ_EXT0]   = GLOBAL_INT_ENABLE
                                     & external_request_enable[`EXT_BIT_0]
                                     & ext_active[`EXT_BIT_0];
    assign next_request[`REQ_GROUP1] = GLOBAL_INT_ENABLE
                                     & pin_change_group_enable[`GROUP_BIT_1]
                                     & group_flags[`GROUP_BIT_1];
    assign next_request[`REQ_GROUP0] = GLOBAL_INT_ENABLE
                                     & pin_change_group_enable[`GROUP_BIT_0]
                                     & group_flags[`GROUP_BIT_0];

    // Wake ignores the global enable so a sleeping core can still be roused
    assign next_wake = |(external_request_enable & ext_active)
                     | |(pin_change_group_enable & group_flags);

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            IRQ_REQUEST  <= 4'h0;
            WAKE_REQUEST <= 1'b0;
        end else begin
            IRQ_REQUEST  <= next_request;
            WAKE_REQUEST <= next_wake;
        end
    end

endmodule

//--- testbench/ext_pin_irq_monitor.sv
// Port-level assertions for the external pin interrupt controller
`timescale 1ns/1ps
module ext_pin_irq_monitor (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RST_B,
    // Pins and core
    input wire logic [1:0]  EXT_REQUEST_PINS,
    input wire logic        GLOBAL_INT_ENABLE,
    input wire logic [3:0]  HANDLER_ENTERED,
    input wire logic [3:0]  IRQ_REQUEST,
    // Register bus
    input wire logic [4:0]  AVS_ADDRESS,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0]  AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST
);
    logic [3:0] sense;
    logic [1:0] enable;
    wire        wr_ok  = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
    wire        rd_ok  = AVS_READ && !AVS_WAITREQUEST;
    wire        cfg0   = enable[0] && GLOBAL_INT_ENABLE;
    wire        low0   = cfg0 && sense[1:0] == 2'b00;
    // A handler entry or flag clear would legally cut the request short
    wire        fall0  = cfg0 && sense[1:0] == 2'b10 && !HANDLER_ENTERED[0]
                         && !(wr_ok && AVS_ADDRESS == 5'h08);
    ////////////////////////////////////////////////////////////////////////////
    // Shadow of the configuration that software wrote
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            sense  <= 4'h0;
            enable <= 2'h0;
        end else if (wr_ok && AVS_ADDRESS == 5'h00) begin
            sense  <= AVS_WRITEDATA[3:0];
        end else if (wr_ok && AVS_ADDRESS == 5'h04) begin
            enable <= AVS_WRITEDATA[1:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);

    a_gie_gates_irq: assert property (!GLOBAL_INT_ENABLE |=> IRQ_REQUEST == 4'h0)
        else $error("request raised without global enable");
    a_enable_gates_irq: assert property (!enable[0] |=> !IRQ_REQUEST[0])
        else $error("request raised without source enable");
    a_level_holds_irq: assert property (
        (!EXT_REQUEST_PINS[0] && low0)[*4] |-> IRQ_REQUEST[0])
        else $error("low level not requesting");
    a_fall_raises_irq: assert property (
        $fell(EXT_REQUEST_PINS[0]) && fall0 ##1 fall0[*3] |=> IRQ_REQUEST[0])
        else $error("falling edge not requested in time");
    a_wait_one_cycle: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("bus answer not after one wait cycle");
    a_wait_single_low: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low for more than one cycle");
    a_wait_has_cause: assert property ($fell(AVS_WAITREQUEST) |-> $past(AVS_READ || AVS_WRITE))
        else $error("bus answer without request");
    a_reserved_read_zero: assert property (rd_ok && AVS_ADDRESS[1:0] == 2'h0
        && AVS_ADDRESS[4:2] <= 3'h4
        |-> AVS_READDATA[31:4] == 28'h0 && (AVS_ADDRESS == 5'h00 || AVS_READDATA[3:2] == 2'h0))
        else $error("unused register bits not zero");
    a_sense_readback: assert property (
        rd_ok && AVS_ADDRESS == 5'h00 |-> AVS_READDATA[3:0] == sense)
        else $error("sense field readback wrong");
endmodule

//--- testbench/pin_core_model.sv
// Pins and processor core facing the interrupt controller
`timescale 1ns/1ps
module pin_core_model (
    // Clock
    input wire logic        clk,
    // Controller side
    input wire logic [3:0]  irq_request,
    output logic     [1:0]  ext_pin,
    output logic     [15:0] pc_pin,
    output logic            global_enable,
    output logic     [3:0]  handler_entered
);
    initial begin
        ext_pin         = 2'h3;
        pc_pin          = 16'h0000;
        global_enable   = 1'b0;
        handler_entered = 4'h0;
    end
    // Pins may be driven by the part itself as outputs; the level is the same to the unit
    task automatic drive_ext(input int idx, input logic v);
        @(posedge clk);
        ext_pin[idx] <= v;
    endtask
    task automatic toggle_pc(input int idx);
        @(posedge clk);
        pc_pin[idx] <= ~pc_pin[idx];
    endtask
    task automatic set_gie(input logic v);
        @(posedge clk);
        global_enable <= v;
    endtask
    // Core enters a pending handler after some latency; skipped when nothing pends
    task automatic enter_handler(input int idx, input int delay);
        repeat (delay + 1) @(posedge clk);
        if (irq_request[idx] === 1'b1) begin
            handler_entered[idx] <= 1'b1;
            @(posedge clk);
            handler_entered <= 4'h0;
        end
    endtask
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the external pin interrupt controller
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0;
    logic        rst_b;
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [1:0]  ext_pin;
    logic [15:0] pc_pin;
    logic        gie;
    logic [3:0]  handler;
    logic [3:0]  irq;
    logic        wake;
    int          failures = 0;
    int          total_checks = 0;
    int          cycles = 0;

    always #5 clk = ~clk;

    ext_pin_irq u_ext_pin_irq (
        .CLK(clk), .RST_B(rst_b), .EXT_REQUEST_PINS(ext_pin), .PIN_CHANGE_INPUTS(pc_pin),
        .GLOBAL_INT_ENABLE(gie), .HANDLER_ENTERED(handler), .IRQ_REQUEST(irq),
        .WAKE_REQUEST(wake), .AVS_ADDRESS(address), .AVS_READ(read), .AVS_WRITE(write),
        .AVS_WRITEDATA(writedata), .AVS_BYTEENABLE(byteenable), .AVS_READDATA(readdata),
        .AVS_WAITREQUEST(waitrequest)
    );
    pin_core_model u_pin_core_model (
        .clk(clk), .irq_request(irq), .ext_pin(ext_pin), .pc_pin(pc_pin),
        .global_enable(gie), .handler_entered(handler)
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_irq(input logic [3:0] exp);
        total_checks++;
        if (irq !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, irq, exp);
        end
    endtask
    function automatic logic [3:0] bit_if(input bit c, input int i);
        return c ? 4'(1 << i) : 4'h0;
    endfunction
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Request held until the edge that samples waitrequest low
    task automatic bus_write(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        address <= a;
        writedata <= d;
        byteenable <= be;
        write <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask
    task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        address <= a;
        read <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        d = readdata;
        read <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_registers();
        logic [4:0]  adr [5] = '{5'h00, 5'h04, 5'h0c, 5'h14, 5'h18};
        logic [31:0] msk [5] = '{32'h0f, 32'h03, 32'h03, 32'hff, 32'hff};
        logic [31:0] d;
        for (int k = 0; k < 5; k++) begin
            bus_read(adr[k], d);
            check_reg(d, 32'h0);
            bus_write(adr[k], 32'hffff_ffff, 4'hf);
            bus_write(adr[k], 32'h0, 4'he);
            bus_read(adr[k], d);
            check_reg(d, msk[k]);
        end
        bus_read(5'h08, d);
        check_reg(d, 32'h0);
        bus_write(5'h03, 32'hffff_ffff, 4'hf);
        bus_read(5'h03, d);
        check_reg(d, 32'h0);
        for (int k = 0; k < 5; k++) bus_write(adr[k], 32'h0, 4'hf);
        $display("test registers done");
    endtask
    task automatic t_sense_modes();
        logic [31:0] d;
        for (int s = 0; s < 4; s++) begin
            for (int i = 0; i < 2; i++) begin
                bus_write(5'h00, 32'(s * 5), 4'hf);
                bus_write(5'h04, 32'(1 << i), 4'hf);
                bus_write(5'h08, 32'h3, 4'hf);
                wait_cyc(6);
                check_irq(4'h0);
                u_pin_core_model.drive_ext(i, 1'b0);
                wait_cyc(6);
                check_irq(bit_if(s != 3, i));
                u_pin_core_model.enter_handler(i, s);
                wait_cyc(3);
                check_irq(bit_if(s == 0, i));
                bus_read(5'h08, d);
                check_reg(d, 32'h0);
                u_pin_core_model.drive_ext(i, 1'b1);
                wait_cyc(6);
                check_irq(bit_if(s[0], i));
                u_pin_core_model.set_gie(1'b0);
                wait_cyc(3);
                check_irq(4'h0);
                check_reg({31'h0, wake}, 32'(s[0]));
                u_pin_core_model.set_gie(1'b1);
                bus_read(5'h08, d);
                check_reg(d, 32'(s[0]) << i);
                check_irq(bit_if(s[0], i));
                bus_write(5'h08, 32'h3, 4'hf);
                wait_cyc(3);
                check_irq(4'h0);
            end
        end
        bus_write(5'h04, 32'h0, 4'hf);
        // Rising edge with the source disabled: flag records it, no request
        u_pin_core_model.drive_ext(0, 1'b0);
        wait_cyc(2);
        u_pin_core_model.drive_ext(0, 1'b1);
        wait_cyc(6);
        check_irq(4'h0);
        bus_read(5'h08, d);
        check_reg(d, 32'h1);
        bus_write(5'h08, 32'h1, 4'hf);
        $display("test sense modes done");
    endtask
    task automatic t_pin_groups();
        logic [31:0] d;
        for (int g = 0; g < 2; g++) begin
            bus_write(5'h0c, 32'(1 << g), 4'hf);
            bus_write(5'(5'h14 + 4 * g), 32'h80, 4'hf);
            u_pin_core_model.set_gie(1'b0);
            u_pin_core_model.toggle_pc(g * 8 + 6);
            wait_cyc(6);
            bus_read(5'h10, d);
            check_reg(d, 32'h0);
            u_pin_core_model.toggle_pc(g * 8 + 7);
            wait_cyc(6);
            check_irq(4'h0);
            bus_read(5'h10, d);
            check_reg(d, 32'(1 << g));
            check_reg({31'h0, wake}, 32'h1);
            u_pin_core_model.set_gie(1'b1);
            wait_cyc(3);
            check_irq(bit_if(1'b1, 2 + g));
            u_pin_core_model.enter_handler(2 + g, 0);
            wait_cyc(3);
            check_irq(4'h0);
            u_pin_core_model.toggle_pc(g * 8 + 7);
            wait_cyc(6);
            check_irq(bit_if(1'b1, 2 + g));
            bus_write(5'h10, 32'(1 << g), 4'hf);
            wait_cyc(3);
            check_irq(4'h0);
            bus_write(5'h0c, 32'h0, 4'hf);
        end
        bus_read(5'h1c, d);
        check_reg(d, 32'h0003_4040);
        $display("test pin groups done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end

    initial begin
        rst_b = 1'b0;
        address = 5'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'h0;
        wait_cyc(16);
        rst_b <= 1'b1;
        wait_cyc(4);
        t_registers();
        u_pin_core_model.set_gie(1'b1);
        t_sense_modes();
        t_pin_groups();
        end_of_test();
    end
endmodule

bind ext_pin_irq ext_pin_irq_monitor u_ext_pin_irq_monitor (
    .CLK(CLK), .RST_B(RST_B), .EXT_REQUEST_PINS(EXT_REQUEST_PINS),
    .GLOBAL_INT_ENABLE(GLOBAL_INT_ENABLE), .HANDLER_ENTERED(HANDLER_ENTERED),
    .IRQ_REQUEST(IRQ_REQUEST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST)
);
